/* File: tcd_top.sv */
// Two-channel transfer controller with APB registers and a bus master port.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module tcd_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  ext_req,
   output logic             m_req,
   input  wire logic        m_gnt,
   output logic             m_valid,
   output logic             m_write,
   output logic [31:0]      m_addr,
   output logic [1:0]       m_size,
   output logic [31:0]      m_wdata,
   input  wire logic [31:0] m_rdata,
   input  wire logic        m_ready,
   input  wire logic        m_err,
   output logic [1:0]       irq,
   output logic             ch1_final_transfer_flag
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      tcd_pkg::tcd_chan_t [1:0] ch; // RULE1
      tcd_pkg::tcd_state_t      st;
      logic                     cur;
      logic                     last;
      logic                     rr_mode;
      logic [3:0]               istat;
      logic [3:0]               imask;
      logic [1:0]               s1;
      logic [1:0]               s2;
      logic [1:0]               s3;
      logic [1:0]               filt;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
      logic                     m_req;
      logic                     m_valid;
      logic                     m_write;
      logic [31:0]              m_addr;
      logic [1:0]               m_size;
      logic [31:0]              m_wdata;
      logic [1:0]               irq;
      logic                     final1;
   } tcd_top_t;

   tcd_top_t   s_reg;
   tcd_top_t   s_next;
   tcd_arb_if  arb_bus ();

   tcd_arb u_arb (
      .a (arb_bus)
   );

   assign arb_bus.rr_mode = s_reg.rr_mode;
   assign arb_bus.last    = s_reg.last;
   assign arb_bus.req     = {s_reg.ch[1].active & (s_reg.st == tcd_pkg::ST_IDLE),
                             s_reg.ch[0].active & (s_reg.st == tcd_pkg::ST_IDLE)};

   // Addresses wrap at the top of the space; a programme must stay inside it.
   // Step size follows the unit size of the channel.
   function automatic logic [31:0] step(input logic [1:0] sz);
      logic [31:0] r;
      r = 32'h0000_0001;
      if (sz == tcd_pkg::SIZE_HALF) begin
         r = 32'h0000_0002;
      end else if (sz == tcd_pkg::SIZE_WORD) begin
         r = 32'h0000_0004;
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic        setup;
   logic        wr_acc;
   logic [4:0]  roff;
   logic        rch;
   logic        in_ch;
   logic [3:0]  ev;
   logic [3:0]  w1c;
   logic [15:0] rem_n;
   logic        c;

   always_comb begin
      s_next  = s_reg;
      ev      = 4'h0;
      w1c     = 4'h0;
      rem_n   = 16'h0000;
      c       = s_reg.cur;
      setup   = psel & ~penable;
      wr_acc  = psel & penable & s_reg.pready & pwrite;
      roff    = paddr[4:0];
      rch     = paddr[5];
      in_ch   = (paddr < tcd_pkg::OFF_PRIO) && (roff <= tcd_pkg::OFF_REM);

      // Three-stage input capture; a new level is accepted once stages agree.
      s_next.s1 = ext_req;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      for (int i = 0; i < 2; i++) begin
         if (s_reg.s2[i] == s_reg.s3[i]) begin
            s_next.filt[i] = s_reg.s3[i];
         end
         // A rising request loads the channel once; a held level does not retrigger.
         if (s_next.filt[i] & ~s_reg.filt[i] & s_reg.ch[i].ext_en & ~s_reg.ch[i].active) begin
            s_next.ch[i].active  = 1'b1; // RULE10
            s_next.ch[i].rem     = s_reg.ch[i].cnt; // RULE5
            s_next.ch[i].cur_src = s_reg.ch[i].src;
            s_next.ch[i].cur_dst = s_reg.ch[i].dst;
         end
      end

      // APB slave: no wait state; the answer is registered in the setup phase so it comes from a flip-flop.
      // Unmapped offsets answer with an error and change nothing.
      s_next.pready = setup;
      if (setup) begin
         s_next.prdata  = 32'h0000_0000;
         s_next.pslverr = 1'b0;
         if (in_ch) begin
            unique case (roff)
               tcd_pkg::OFF_SRC:  s_next.prdata = s_reg.ch[rch].src;
               tcd_pkg::OFF_DST:  s_next.prdata = s_reg.ch[rch].dst;
               tcd_pkg::OFF_CNT:  s_next.prdata = {16'h0000, s_reg.ch[rch].cnt};
               tcd_pkg::OFF_CTRL: s_next.prdata = {25'h0000000, s_reg.ch[rch].ext_en,
                                                   s_reg.ch[rch].burst,
                                                   s_reg.ch[rch].dst_inc,
                                                   s_reg.ch[rch].src_inc,
                                                   s_reg.ch[rch].size,
                                                   s_reg.ch[rch].active};
               tcd_pkg::OFF_REM:  s_next.prdata = {16'h0000, s_reg.ch[rch].rem};
               default:           s_next.pslverr = 1'b1;
            endcase
         end else if (paddr == tcd_pkg::OFF_PRIO) begin
            s_next.prdata = {31'h00000000, s_reg.rr_mode};
         end else if (paddr == tcd_pkg::OFF_ISTAT) begin
            s_next.prdata = {28'h0000000, s_reg.istat};
         end else if (paddr == tcd_pkg::OFF_IMASK) begin
            s_next.prdata = {28'h0000000, s_reg.imask};
         end else if (paddr == tcd_pkg::OFF_STATUS) begin
            s_next.prdata = {30'h00000000, s_reg.ch[1].active, s_reg.ch[0].active};
         end else begin
            s_next.pslverr = 1'b1;
         end
      end else if (psel & penable & s_reg.pready) begin
         s_next.prdata  = 32'h0000_0000;
         s_next.pslverr = 1'b0;
      end

      if (wr_acc & ~s_reg.pslverr) begin
         if (in_ch) begin
            unique case (roff)
               tcd_pkg::OFF_SRC: s_next.ch[rch].src = pwdata;
               tcd_pkg::OFF_DST: s_next.ch[rch].dst = pwdata;
               tcd_pkg::OFF_CNT: s_next.ch[rch].cnt = pwdata[15:0]; // RULE5
               tcd_pkg::OFF_CTRL: begin
                  s_next.ch[rch].size    = pwdata[tcd_pkg::CTRL_SIZE_LO +: 2]; // RULE6
                  s_next.ch[rch].src_inc = pwdata[tcd_pkg::CTRL_SRC_INC]; // RULE2
                  s_next.ch[rch].dst_inc = pwdata[tcd_pkg::CTRL_DST_INC]; // RULE2
                  s_next.ch[rch].burst   = pwdata[tcd_pkg::CTRL_BURST];
                  s_next.ch[rch].ext_en  = pwdata[tcd_pkg::CTRL_EXT_EN];
                  if (pwdata[tcd_pkg::CTRL_START] & ~s_reg.ch[rch].active) begin
                     s_next.ch[rch].active  = 1'b1; // RULE9
                     s_next.ch[rch].rem     = s_reg.ch[rch].cnt;
                     s_next.ch[rch].cur_src = s_reg.ch[rch].src;
                     s_next.ch[rch].cur_dst = s_reg.ch[rch].dst;
                  end
               end
               default: begin
               end
            endcase
         end else if (paddr == tcd_pkg::OFF_PRIO) begin
            s_next.rr_mode = pwdata[0];
         end else if (paddr == tcd_pkg::OFF_ISTAT) begin
            w1c = pwdata[3:0];
         end else if (paddr == tcd_pkg::OFF_IMASK) begin
            s_next.imask = pwdata[3:0];
         end
      end

      // Transfer engine: read the source, then write the destination.
      // Cycle steal goes back to idle for at least one cycle, which leaves the bus to others.
      unique case (s_reg.st)
         tcd_pkg::ST_IDLE: begin
            if (arb_bus.grant_valid) begin
               s_next.cur   = arb_bus.grant_ch;
               s_next.last  = arb_bus.grant_ch; // RULE4
               s_next.m_req = 1'b1; // RULE7
               s_next.st    = tcd_pkg::ST_WAIT_GNT;
            end
         end
         tcd_pkg::ST_WAIT_GNT: begin
            if (m_gnt) begin
               s_next.m_valid = 1'b1; // RULE15
               s_next.m_write = 1'b0;
               s_next.m_addr  = s_reg.ch[c].cur_src; // RULE16
               s_next.m_size  = s_reg.ch[c].size; // RULE6
               s_next.final1  = c & (s_reg.ch[c].rem == 16'h0000); // RULE14
               s_next.st      = tcd_pkg::ST_READ;
            end
         end
         tcd_pkg::ST_READ: begin
            if (m_ready) begin
               if (m_err) begin
                  ev[tcd_pkg::IST_ERR + c] = 1'b1; // RULE11
               end else begin
                  s_next.m_write = 1'b1; // RULE16
                  s_next.m_addr  = s_reg.ch[c].cur_dst;
                  s_next.m_wdata = m_rdata;
                  s_next.st      = tcd_pkg::ST_WRITE;
               end
            end
         end
         tcd_pkg::ST_WRITE: begin
            if (m_ready) begin
               rem_n = s_reg.ch[c].rem - 16'h0001;
               if (s_reg.ch[c].src_inc) begin
                  s_next.ch[c].cur_src = s_reg.ch[c].cur_src + step(s_reg.ch[c].size); // RULE16
               end
               if (s_reg.ch[c].dst_inc) begin
                  s_next.ch[c].cur_dst = s_reg.ch[c].cur_dst + step(s_reg.ch[c].size); // RULE16
               end
               if (m_err) begin
                  ev[tcd_pkg::IST_ERR + c] = 1'b1; // RULE11
               end else if (s_reg.ch[c].rem == 16'h0000) begin
                  ev[tcd_pkg::IST_DONE + c] = 1'b1; // RULE11
               end else if (s_reg.ch[c].burst) begin
                  s_next.ch[c].rem = rem_n;
                  s_next.m_write   = 1'b0; // RULE8
                  s_next.m_addr    = s_next.ch[c].cur_src;
                  s_next.final1    = c & (rem_n == 16'h0000); // RULE14
                  s_next.st        = tcd_pkg::ST_READ;
               end else begin
                  s_next.ch[c].rem = rem_n;
                  s_next.m_valid   = 1'b0;
                  s_next.m_write   = 1'b0;
                  s_next.m_req     = 1'b0; // RULE7
                  s_next.final1    = 1'b0;
                  s_next.st        = tcd_pkg::ST_IDLE;
               end
            end
         end
      endcase

      // An ended programme, by completion or by error, releases the bus.
      // An error stops the channel at once; the remaining count is left for software.
      if (ev != 4'h0) begin
         s_next.ch[c].active = 1'b0; // RULE5
         s_next.m_valid      = 1'b0;
         s_next.m_write      = 1'b0;
         s_next.m_req        = 1'b0; // RULE8
         s_next.final1       = 1'b0;
         s_next.st           = tcd_pkg::ST_IDLE;
      end

      // New events win over a clear written in the same cycle.
      s_next.istat = (s_reg.istat & ~w1c) | ev;
      for (int i = 0; i < 2; i++) begin
         s_next.irq[i] = (s_next.istat[i] & ~s_next.imask[i]) // RULE13
                       | (s_next.istat[i + 2] & ~s_next.imask[i + 2]);
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata                  = s_reg.prdata;
   assign pready                  = s_reg.pready;
   assign pslverr                 = s_reg.pslverr;
   assign m_req                   = s_reg.m_req;
   assign m_valid                 = s_reg.m_valid;
   assign m_write                 = s_reg.m_write;
   assign m_addr                  = s_reg.m_addr;
   assign m_size                  = s_reg.m_size;
   assign m_wdata                 = s_reg.m_wdata;
   assign irq                     = s_reg.irq; // RULE12
   assign ch1_final_transfer_flag = s_reg.final1; // RULE14

endmodule // tcd_top

/* File: tcd_pkg.sv */
// Constants, register map and types of the two-channel transfer controller.
// What this block does
// (RULE1) Two independent channels, any memory or I/O pairing.
// (RULE2) Memory-memory, peripheral-memory, peripheral-peripheral per channel.
// (RULE3) Fixed priority serves channel zero first.
// (RULE4) Rotating priority demotes most recently granted channel.
// (RULE5) Up to 65,536 transfers, then channel stops.
// (RULE6) Unit size byte, half-word or word.
// (RULE7) Cycle steal requests bus per transfer.
// (RULE8) Burst keeps bus request until count done.
// (RULE9) Software request bit starts a channel.
// (RULE10) Dedicated external request input starts its channel.
// (RULE11) Interrupt on count done or on error.
// (RULE12) Separate interrupt output per channel.
// (RULE13) Per-channel mask suppresses its interrupt output.
// (RULE14) Channel one flag: final transfer has started.
// (RULE15) No bus transfer before arbiter grant.
// (RULE16) Read source then write destination, addresses step.
package tcd_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] CH_STRIDE   = 8'h20;
   localparam logic [4:0] OFF_SRC     = 5'h00;
   localparam logic [4:0] OFF_DST     = 5'h04;
   localparam logic [4:0] OFF_CNT     = 5'h08;
   localparam logic [4:0] OFF_CTRL    = 5'h0C;
   localparam logic [4:0] OFF_REM     = 5'h10;
   localparam logic [7:0] OFF_PRIO    = 8'h40;
   localparam logic [7:0] OFF_ISTAT   = 8'h44;
   localparam logic [7:0] OFF_IMASK   = 8'h48;
   localparam logic [7:0] OFF_STATUS  = 8'h4C;

   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   localparam int CTRL_START   = 0;
   localparam int CTRL_SIZE_LO = 1;
   localparam int CTRL_SRC_INC = 3;
   localparam int CTRL_DST_INC = 4;
   localparam int CTRL_BURST   = 5;
   localparam int CTRL_EXT_EN  = 6;

   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // Interrupt status layout: done bits low, error bits above.
   localparam int IST_DONE = 0;
   localparam int IST_ERR  = 2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [15:0] RST_CNT   = 16'h0000;
   localparam logic [3:0]  RST_IMASK = 4'h0;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_GNT,
      ST_READ,
      ST_WRITE
   } tcd_state_t;

   typedef struct packed {
      logic [31:0] src;
      logic [31:0] dst;
      logic [15:0] cnt;
      logic [1:0]  size;
      logic        src_inc;
      logic        dst_inc;
      logic        burst;
      logic        ext_en;
      logic        active;
      logic [15:0] rem;
      logic [31:0] cur_src;
      logic [31:0] cur_dst;
   } tcd_chan_t;

endpackage

/* File: tcd_arb_if.sv */
// Interface between the transfer engine and its channel arbiter.
`timescale 1ns/1ps
interface tcd_arb_if;
   logic [1:0] req;
   logic       rr_mode;
   logic       last;
   logic       grant_valid;
   logic       grant_ch;

   modport engine (output req, output rr_mode, output last,
                   input grant_valid, input grant_ch);
   modport arb    (input req, input rr_mode, input last,
                   output grant_valid, output grant_ch);
endinterface

/* File: tcd_arb.sv */
// Channel arbiter: fixed or rotating priority between two channels.
`timescale 1ns/1ps
module tcd_arb (
   tcd_arb_if.arb a
);
   always_comb begin
      a.grant_valid = |a.req;
      a.grant_ch    = 1'b0;
      if (a.req == 2'h3) begin
         if (a.rr_mode) begin
            a.grant_ch = ~a.last; // RULE4
         end else begin
            a.grant_ch = 1'b0; // RULE3
         end
      end else begin
         a.grant_ch = a.req[1];
      end
   end
endmodule // tcd_arb

/* File: tcd_bus_model.sv */
// Behavioural arbiter and memory on the master port of the transfer controller.
`timescale 1ns/1ps
module tcd_bus_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        m_req,
   output logic             m_gnt,
   input  wire logic        m_valid,
   input  wire logic        m_write,
   input  wire logic [31:0] m_addr,
   input  wire logic [31:0] m_wdata,
   output logic [31:0]      m_rdata,
   output logic             m_ready,
   output logic             m_err,
   input  wire logic        err_on,
   input  wire logic [1:0]  lat,
   output int               wr_cnt,
   output logic [31:0]      wr_addr,
   output logic [31:0]      wr_data
);
   logic [1:0] wait_q;
   // Data outside the ready cycle is inverted so a stale capture cannot pass.
   assign m_ready = m_valid && wait_q == lat;
   assign m_rdata = m_ready ? m_addr ^ 32'hA5A5_0000 : ~(m_addr ^ 32'hA5A5_0000);
   assign m_err   = m_ready && err_on;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_gnt  <= 1'b0;
         wait_q <= 2'h0;
         wr_cnt <= 0;
      end else begin
         m_gnt  <= m_req;
         wait_q <= (m_ready || !m_valid) ? 2'h0 : wait_q + 2'h1;
         if (m_ready && m_write && !err_on) begin
            wr_cnt  <= wr_cnt + 1;
            wr_addr <= m_addr;
            wr_data <= m_wdata;
         end
      end
   end
endmodule // tcd_bus_model

/* File: tcd_top_sva.sv */
// Port-level assertions of the transfer controller.
`timescale 1ns/1ps
module tcd_top_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        m_req,
   input wire logic        m_gnt,
   input wire logic        m_valid,
   input wire logic        m_write,
   input wire logic [31:0] m_addr,
   input wire logic [1:0]  m_size,
   input wire logic        m_ready,
   input wire logic        m_err,
   input wire logic [1:0]  irq,
   input wire logic        ch1_final_transfer_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic cause_q;
   // An interrupt may only rise shortly after a bus answer or a register write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cause_q <= 1'b0;
      else cause_q <= (m_valid && m_ready) || (psel && penable && pwrite);
   end
   a_valid_needs_gnt: assert property (m_valid |-> m_gnt)
      else $error("bus cycle without grant");
   a_valid_after_gnt: assert property ($rose(m_valid) |-> $past(m_req) && $past(m_gnt))
      else $error("bus cycle not preceded by request and grant");
   a_read_then_write: assert property (m_valid && m_ready && !m_write && !m_err |=> m_valid && m_write)
      else $error("read not followed by write");
   a_request_held: assert property (m_valid && !m_ready |=> m_valid && $stable(m_addr) && $stable(m_write))
      else $error("bus request changed before ready");
   a_size_legal: assert property (m_valid |-> m_size != 2'h3)
      else $error("illegal unit size");
   a_req_gap: assert property ($fell(m_req) |-> !m_valid ##1 !m_valid)
      else $error("bus cycle without idle gap after release");
   a_err_ends_chan: assert property (m_valid && m_ready && m_err |=> !m_valid)
      else $error("transfer continued after error");
   a_irq_cause: assert property ((irq & ~$past(irq)) != 2'h0 |-> cause_q || $past(cause_q))
      else $error("interrupt rose without cause");
   a_mask_all: assert property (psel && penable && pready && pwrite && paddr == tcd_pkg::OFF_IMASK
      && pwdata[3:0] == 4'hF |=> ##1 irq == 2'h0)
      else $error("masked interrupt still high");
   a_flag_in_xfer: assert property (ch1_final_transfer_flag |-> m_req || $past(m_req))
      else $error("final transfer flag outside transfer");
   c_write_done: cover property (m_valid && m_write && m_ready);
   c_error: cover property (m_valid && m_ready && m_err);
   c_flag: cover property ($rose(ch1_final_transfer_flag));
endmodule // tcd_top_sva
bind tcd_top tcd_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .m_req(m_req),
   .m_gnt(m_gnt), .m_valid(m_valid), .m_write(m_write), .m_addr(m_addr), .m_size(m_size),
   .m_ready(m_ready), .m_err(m_err), .irq(irq),
   .ch1_final_transfer_flag(ch1_final_transfer_flag));

/* File: testbench.sv */
// Self-checking bench of the transfer controller with its bus partner.
`timescale 1ns/1ps
module testbench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [1:0]  ext_req = 2'h0;
   logic        err_on = 1'b0;
   logic [1:0]  lat = 2'h0;
   logic        pready, pslverr, m_req, m_gnt, m_valid, m_write, m_ready, m_err, flag, e;
   logic [31:0] prdata, m_addr, m_wdata, m_rdata, wr_addr, wr_data, q;
   logic [1:0]  m_size, irq, wr_size;
   logic [3:0]  rd_hist;
   int          wr_cnt, num_errors, tests_run, falls, flags, cycles;
   always #12.5 pclk = ~pclk;
   tcd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_req(ext_req), .m_req(m_req), .m_gnt(m_gnt), .m_valid(m_valid),
      .m_write(m_write), .m_addr(m_addr), .m_size(m_size), .m_wdata(m_wdata),
      .m_rdata(m_rdata), .m_ready(m_ready), .m_err(m_err), .irq(irq),
      .ch1_final_transfer_flag(flag));
   tcd_bus_model u_bus (.pclk(pclk), .presetn(presetn), .m_req(m_req), .m_gnt(m_gnt),
      .m_valid(m_valid), .m_write(m_write), .m_addr(m_addr), .m_wdata(m_wdata),
      .m_rdata(m_rdata), .m_ready(m_ready), .m_err(m_err), .err_on(err_on), .lat(lat),
      .wr_cnt(wr_cnt), .wr_addr(wr_addr), .wr_data(wr_data));
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if ($fell(m_req)) falls <= falls + 1;
      if ($rose(flag)) flags <= flags + 1;
      if (m_valid && m_ready && !m_write) rd_hist <= {rd_hist[2:0], m_addr[13]};
      if (m_valid && m_ready && m_write) wr_size <= m_size;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         summarize;
      end
   end
   task summarize;
      $display("errors=%0d checks=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // The request is held until pready is sampled high, as the bus demands.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_st(input logic [3:0] m);
      repeat (100) begin
         apb(1'b0, tcd_pkg::OFF_ISTAT, 32'h0);
         if ((q[3:0] & m) == m) break;
      end
      chk(q[3:0] & m, m);
   endtask
   task prog(input logic c, input logic [31:0] s, input logic [31:0] d, input logic [15:0] n,
             input logic [6:0] ctl);
      apb(1'b1, {2'h0, c, tcd_pkg::OFF_SRC}, s);
      apb(1'b1, {2'h0, c, tcd_pkg::OFF_DST}, d);
      apb(1'b1, {2'h0, c, tcd_pkg::OFF_CNT}, {16'h0, n});
      apb(1'b1, {2'h0, c, tcd_pkg::OFF_CTRL}, {25'h0, ctl});
   endtask
   task clr;
      apb(1'b1, tcd_pkg::OFF_ISTAT, 32'hF);
   endtask
   task t_regs;
      logic [7:0] ra [4];
      ra = '{8'h08, 8'h2C, tcd_pkg::OFF_ISTAT, tcd_pkg::OFF_IMASK};
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         chk(q, tcd_pkg::RST_WORD);
      end
      apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
      chk(e, 1'b1);
      apb(1'b0, 8'h3C, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
   endtask
   task t_xfer(input logic c, input logic [1:0] sz, input logic [15:0] n, input logic b);
      int w0;
      int f0;
      w0 = wr_cnt;
      f0 = falls;
      prog(c, 32'h1000, 32'h3000, n, {1'b0, b, 2'h3, sz, 1'b1});
      wait_st(4'h1 << c);
      chk(wr_cnt - w0, n + 1);
      chk(wr_addr, 32'h3000 + ({16'h0, n} << sz));
      chk({30'h0, wr_size}, {30'h0, sz});
      chk(wr_data, (32'h1000 + ({16'h0, n} << sz)) ^ 32'hA5A5_0000);
      chk(falls - f0, b ? 1 : n + 1);
      chk(irq, 2'h1 << c);
      clr;
      repeat (2) @(posedge pclk);
      chk(irq, 2'h0);
   endtask
   task t_mask;
      apb(1'b1, tcd_pkg::OFF_IMASK, 32'hF);
      prog(1'b0, 32'h1000, 32'h3000, 16'h0, 7'h1D);
      wait_st(4'h1);
      chk(irq, 2'h0);
      apb(1'b1, tcd_pkg::OFF_IMASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 2'h1);
      clr;
   endtask
   task t_err;
      err_on <= 1'b1;
      prog(1'b0, 32'h1000, 32'h3000, 16'h3, 7'h1D);
      wait_st(4'h4);
      chk(irq, 2'h1);
      apb(1'b0, tcd_pkg::OFF_STATUS, 32'h0);
      chk(q[1:0], 2'h0);
      err_on <= 1'b0;
      clr;
   endtask
   task t_ext;
      int f0;
      f0 = flags;
      prog(1'b1, 32'h1000, 32'h3000, 16'h2, 7'h5C);
      apb(1'b0, tcd_pkg::OFF_STATUS, 32'h0);
      chk(q[1:0], 2'h0);
      ext_req <= 2'h2;
      repeat (2) @(posedge pclk);
      ext_req <= 2'h0;
      wait_st(4'h2);
      chk(flags - f0, 1);
      chk(irq, 2'h2);
      clr;
   endtask
   task t_prio(input logic rr, input logic [3:0] ex);
      apb(1'b1, tcd_pkg::OFF_PRIO, {31'h0, rr});
      prog(1'b0, 32'h1000, 32'h3000, 16'h1, 7'h5C);
      prog(1'b1, 32'h2000, 32'h4000, 16'h1, 7'h5C);
      ext_req <= 2'h3;
      repeat (2) @(posedge pclk);
      ext_req <= 2'h0;
      wait_st(4'h3);
      chk(rd_hist, ex);
      clr;
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_xfer(1'b0, tcd_pkg::SIZE_BYTE, 16'h3, 1'b0);
      t_xfer(1'b1, tcd_pkg::SIZE_HALF, 16'h1, 1'b1);
      lat <= 2'h2;
      t_xfer(1'b0, tcd_pkg::SIZE_WORD, 16'h0, 1'b1);
      t_xfer(1'b1, tcd_pkg::SIZE_WORD, 16'h2, 1'b0);
      lat <= 2'h0;
      t_mask;
      t_err;
      t_ext;
      t_prio(1'b0, 4'h3);
      t_prio(1'b1, 4'h5);
      summarize;
   end
endmodule // testbench
